// >>> verilog/bst_pkg.sv
// Notes on behaviour
// - Sixteen-state controller, self-reset at power-up
// - Instruction 3, bypass 1, ID 32, boundary 107
// - Undriven mode or data input reads one
// - Code 001 selects ID register
// - Code 010 boundary, data pins high-Z
// - Code 100 sample/preload, no high-Z
// - Code 111 bypass, cleared on capture
// - ID fields revision, device, manufacturer
// - ID bit zero always one
// - 107 cells, cell 48 internal
`default_nettype none
package bst_pkg;
    // ==================================================
    // Register sizes
    localparam int INSTR_W  = 3;
    localparam int ID_W     = 32;
    localparam int BND_W    = 107;
    localparam int BND_INT  = 47;     // Zero-based index of cell 48
    // ==================================================
    // Instruction codes
    localparam logic [2:0] INS_EXTEST  = 3'h0;
    localparam logic [2:0] INS_IDCODE  = 3'h1;
    localparam logic [2:0] INS_SAMPZ   = 3'h2;
    localparam logic [2:0] INS_SAMPLE  = 3'h4;
    localparam logic [2:0] INS_BYPASS  = 3'h7;
    localparam logic [2:0] INS_RESET   = INS_IDCODE;
    localparam logic [1:0] IR_CAPTURE  = 2'h1;
    // ==================================================
    // ID register fields, values arbitrary
    localparam logic [2:0]  ID_REV     = 3'h1;   // Arbitrary
    localparam logic [16:0] ID_DEV     = 17'h0_1234; // Arbitrary
    localparam logic [10:0] ID_MFR     = 11'h0_5a5;  // Arbitrary
    // ==================================================
    // Controller states
    typedef enum logic [3:0] {
        ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h3, ST_CAP_DR = 4'h2,
        ST_SH_DR = 4'h6, ST_EX1_DR = 4'h7, ST_PAU_DR = 4'h5, ST_EX2_DR = 4'h4,
        ST_UPD_DR = 4'hc, ST_SEL_IR = 4'hd, ST_CAP_IR = 4'hf, ST_SH_IR = 4'he,
        ST_EX1_IR = 4'ha, ST_PAU_IR = 4'hb, ST_EX2_IR = 4'h9, ST_UPD_IR = 4'h8
    } bst_state_type;
endpackage
`default_nettype wire

// >>> verilog/bst_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; output moves when stages two and three agree
module bst_sync #(
    parameter logic INIT = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output var  logic dout
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    // ==================================================
    // Stage one is read only by stage two
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
            dout <= INIT;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                dout <= s3_r;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verilog/bst_tap.sv
`timescale 1ns/1ps
`default_nettype none
// Boundary-scan test port; tap logic on test clock, pad side on ref_clk
module bst_tap #(
    parameter int BND_W = bst_pkg::BND_W
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             tck,
    input  wire logic             tms_pin,
    input  wire logic             tms_drv,
    input  wire logic             tdi_pin,
    input  wire logic             tdi_drv,
    output var  logic             tdo,
    output var  logic             tdo_oe,
    input  wire logic [BND_W-1:0] pad_in,
    output var  logic [BND_W-1:0] pad_out,
    output var  logic             pad_test_drive,
    output var  logic             pad_hiz,
    output var  logic [2:0]       instr_now
);
    // ==================================================
    // Power-up reset of the test domain, released synchronously on tck
    logic por1_r;
    logic por_n_r;
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            por1_r  <= 1'b0;
            por_n_r <= 1'b0;
        end else begin
            por1_r  <= 1'b1;
            por_n_r <= por1_r;
        end
    end

    // Undriven inputs read as one
    wire tms = tms_drv ? tms_pin : 1'b1;
    wire tdi = tdi_drv ? tdi_pin : 1'b1;

    // ==================================================
    // Controller
    bst_pkg::bst_state_type st_r;
    bst_pkg::bst_state_type st_nxt;
    always_comb begin
        case (st_r)
            bst_pkg::ST_RESET:  st_nxt = tms ? bst_pkg::ST_RESET  : bst_pkg::ST_IDLE;
            bst_pkg::ST_IDLE:   st_nxt = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
            bst_pkg::ST_SEL_DR: st_nxt = tms ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
            bst_pkg::ST_CAP_DR: st_nxt = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
            bst_pkg::ST_SH_DR:  st_nxt = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
            bst_pkg::ST_EX1_DR: st_nxt = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
            bst_pkg::ST_PAU_DR: st_nxt = tms ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
            bst_pkg::ST_EX2_DR: st_nxt = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
            bst_pkg::ST_UPD_DR: st_nxt = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
            bst_pkg::ST_SEL_IR: st_nxt = tms ? bst_pkg::ST_RESET  : bst_pkg::ST_CAP_IR;
            bst_pkg::ST_CAP_IR: st_nxt = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
            bst_pkg::ST_SH_IR:  st_nxt = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
            bst_pkg::ST_EX1_IR: st_nxt = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
            bst_pkg::ST_PAU_IR: st_nxt = tms ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
            bst_pkg::ST_EX2_IR: st_nxt = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
            bst_pkg::ST_UPD_IR: st_nxt = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
            default:            st_nxt = bst_pkg::ST_RESET;
        endcase
    end

    // Sixteen states, forced to reset at power-up
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= bst_pkg::ST_RESET;
        end else if (!por_n_r) begin
            st_r <= bst_pkg::ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==================================================
    // Decodes
    wire in_reset = (st_r == bst_pkg::ST_RESET);
    wire cap_ir   = (st_r == bst_pkg::ST_CAP_IR);
    wire sh_ir    = (st_r == bst_pkg::ST_SH_IR);
    wire upd_ir   = (st_r == bst_pkg::ST_UPD_IR);
    wire cap_dr   = (st_r == bst_pkg::ST_CAP_DR);
    wire sh_dr    = (st_r == bst_pkg::ST_SH_DR);
    wire upd_dr   = (st_r == bst_pkg::ST_UPD_DR);

    // ==================================================
    // Instruction shift and hold registers
    logic [bst_pkg::INSTR_W-1:0] ir_sh_r;
    logic [bst_pkg::INSTR_W-1:0] ir_r;
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            ir_sh_r <= '0;
        end else if (cap_ir) begin
            ir_sh_r <= {1'b0, bst_pkg::IR_CAPTURE};
        end else if (sh_ir) begin
            ir_sh_r <= {tdi, ir_sh_r[bst_pkg::INSTR_W-1:1]};
        end
    end

    // Hold register updates on falling edge, as customary
    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            ir_r <= bst_pkg::INS_RESET;
        end else if (in_reset) begin
            ir_r <= bst_pkg::INS_RESET;
        end else if (upd_ir) begin
            ir_r <= ir_sh_r;
        end
    end

    wire instr_bit_high = ir_r[2];
    wire instr_bit_mid  = ir_r[1];
    wire instr_bit_low  = ir_r[0];
    wire sel_id   = (ir_r == bst_pkg::INS_IDCODE);
    wire sel_byp  = (ir_r == bst_pkg::INS_BYPASS);
    // Codes 000, 010, 100 all use the boundary chain
    wire sel_bnd  = ~instr_bit_low & ~(instr_bit_high & instr_bit_mid);
    wire drive_ex = (ir_r == bst_pkg::INS_EXTEST);
    wire hiz_req  = (ir_r == bst_pkg::INS_SAMPZ);

    // ==================================================
    // Data registers
    localparam logic [bst_pkg::ID_W-1:0] ID_VAL =
        {bst_pkg::ID_REV, bst_pkg::ID_DEV, bst_pkg::ID_MFR, 1'b1};
    logic [bst_pkg::ID_W-1:0] id_sh_r;
    logic                     byp_r;
    logic [BND_W-1:0]         bnd_sh_r;
    logic [BND_W-1:0]         bnd_upd_r;
    logic [BND_W-1:0]         pad_cap;

    // Pads sampled into the chain; internal cell captures its update value
    always_comb begin
        pad_cap = pad_in;
        pad_cap[bst_pkg::BND_INT] = bnd_upd_r[bst_pkg::BND_INT];
    end

    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            id_sh_r  <= '0;
            byp_r    <= 1'b0;
            bnd_sh_r <= '0;
        end else begin
            if (cap_dr && sel_id) begin
                id_sh_r <= ID_VAL;
            end else if (sh_dr && sel_id) begin
                id_sh_r <= {tdi, id_sh_r[bst_pkg::ID_W-1:1]};
            end
            // Cleared on capture, keeps last shifted bit afterwards
            if (cap_dr && sel_byp) begin
                byp_r <= 1'b0;
            end else if (sh_dr && sel_byp) begin
                byp_r <= tdi;
            end
            if (cap_dr && sel_bnd) begin
                bnd_sh_r <= pad_cap;
            end else if (sh_dr && sel_bnd) begin
                bnd_sh_r <= {tdi, bnd_sh_r[BND_W-1:1]};
            end
        end
    end

    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            bnd_upd_r <= '0;
        end else if (upd_dr && sel_bnd) begin
            bnd_upd_r <= bnd_sh_r;
        end
    end

    // ==================================================
    // Serial output, changed on the falling edge
    wire tdo_mux = sh_ir   ? ir_sh_r[0]  :
                   sel_id  ? id_sh_r[0]  :
                   sel_bnd ? bnd_sh_r[0] : byp_r;
    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo    <= tdo_mux;
            tdo_oe <= sh_ir | sh_dr;
        end
    end

    // ==================================================
    // Pad-side controls cross to ref_clk; test clock may stop when idle
    logic ex_tck_r;
    logic hiz_tck_r;
    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            ex_tck_r  <= 1'b0;
            hiz_tck_r <= 1'b0;
        end else begin
            ex_tck_r  <= drive_ex & ~in_reset;
            hiz_tck_r <= hiz_req;
        end
    end

    logic ex_ref;
    logic hiz_ref;
    bst_sync #(.INIT(1'b0)) u_sync_ex (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .din   (ex_tck_r),
        .dout  (ex_ref)
    );
    bst_sync #(.INIT(1'b0)) u_sync_hiz (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .din   (hiz_tck_r),
        .dout  (hiz_ref)
    );

    // Pad values are quasi-static once the drive flag has settled
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_test_drive <= 1'b0;
            pad_hiz        <= 1'b0;
            pad_out        <= '0;
            instr_now      <= bst_pkg::INS_RESET;
        end else begin
            pad_test_drive <= ex_ref;
            pad_hiz        <= hiz_ref;
            pad_out        <= ex_ref ? bnd_upd_r : '0;
            instr_now      <= ir_r;
        end
    end
endmodule
`default_nettype wire

// >>> tb/bst_tap_props.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================
// Port checker
module bst_tap_props #(
    parameter int BND_W = bst_pkg::BND_W
) (
    input wire logic             ref_clk,
    input wire logic             rst_n,
    input wire logic             tck,
    input wire logic             tms_pin,
    input wire logic             tms_drv,
    input wire logic             tdo_oe,
    input wire logic [BND_W-1:0] pad_out,
    input wire logic             pad_test_drive,
    input wire logic             pad_hiz,
    input wire logic [2:0]       instr_now
);
    // Undriven mode select counts as one
    wire logic ms = tms_pin || !tms_drv;
    // Five ones in a row seen on tck; held until a shift starts
    logic [2:0] ones_r;
    logic       tlr_seen_r;
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            ones_r     <= 3'h0;
            tlr_seen_r <= 1'b0;
        end else begin
            ones_r <= !ms ? 3'h0 : ((ones_r == 3'h5) ? ones_r : ones_r + 3'h1);
            if (tdo_oe) begin
                tlr_seen_r <= 1'b0;
            end else if (ms && ones_r >= 3'h4) begin
                tlr_seen_r <= 1'b1;
            end
        end
    end
    // Pad flags follow the instruction within six ref_clk cycles
    hiz_on_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (instr_now == bst_pkg::INS_SAMPZ) [*6] |-> pad_hiz) else $error("no high-Z");
    hiz_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (instr_now != bst_pkg::INS_SAMPZ) [*6] |-> !pad_hiz) else $error("stray high-Z");
    drive_on_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (instr_now == bst_pkg::INS_EXTEST) [*6] |-> pad_test_drive) else $error("no drive");
    pad_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (instr_now != bst_pkg::INS_EXTEST) [*6] |-> !pad_test_drive && pad_out == '0)
        else $error("pads driven");
    mode_excl_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(pad_hiz && pad_test_drive)) else $error("high-Z and drive");
    // Five ones on mode select always land in reset with the reset code
    // Checked on ref_clk, since instr_now only follows a ref_clk later
    tlr_reload_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tlr_seen_r [*6] |-> instr_now == bst_pkg::INS_IDCODE) else $error("no reset code");
    // Shift entered on a zero, left on a one
    oe_rise_a: assert property (@(posedge tck) disable iff (!rst_n)
        $rose(tdo_oe) |-> !$past(ms)) else $error("bad shift entry");
    oe_fall_a: assert property (@(posedge tck) disable iff (!rst_n)
        $fell(tdo_oe) |-> $past(ms)) else $error("bad shift exit");
    cover property (@(posedge ref_clk) pad_hiz);
    cover property (@(posedge ref_clk) pad_test_drive);
    cover property (@(posedge tck) $rose(tdo_oe));
endmodule
bind bst_tap bst_tap_props #(.BND_W(BND_W)) u_bst_tap_props (.ref_clk(ref_clk),
    .rst_n(rst_n), .tck(tck), .tms_pin(tms_pin), .tms_drv(tms_drv), .tdo_oe(tdo_oe),
    .pad_out(pad_out), .pad_test_drive(pad_test_drive), .pad_hiz(pad_hiz),
    .instr_now(instr_now));
`default_nettype wire

// >>> tb/bst_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================
// Scan controller; clock stands low between frames
module bst_ctl_model (
    output var logic tck,
    output var logic tms_pin,
    output var logic tms_drv,
    output var logic tdi_pin,
    output var logic tdi_drv,
    input  wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms_pin = 1'b1;
        tms_drv = 1'b1;
        tdi_pin = 1'b1;
        tdi_drv = 1'b1;
    end
    // One 6 ns cycle: inputs set while low, tdo taken at the rise
    task automatic step(input logic m, input logic d, output logic q);
        tms_pin = m;
        tdi_pin = d;
        #3;
        tck = 1'b1;
        q = tdo;
        #3;
        tck = 1'b0;
    endtask
    // Five ones then idle; undriven pins show zero so only the flag helps
    task automatic tlr(input logic drv);
        logic q;
        tms_drv = drv;
        tdi_drv = drv;
        repeat (5) step(drv, drv, q);
        tms_drv = 1'b1;
        tdi_drv = 1'b1;
        step(1'b0, 1'b0, q);
    endtask
    // Full IR or DR frame from idle back to idle, LSB first
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b0, q);
        if (ir) begin
            step(1'b1, 1'b0, q);
        end
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask
    // tdo is only read, never loaded
endmodule
`default_nettype wire

// >>> tb/boundary_scan_test_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_test_port_test;
    localparam int W = bst_pkg::BND_W;
    logic         ref_clk = 1'b0;
    logic         rst_n   = 1'b0;
    logic [W-1:0] pad_in  = '0;
    logic [W-1:0] pad_out;
    logic [W-1:0] mask;
    logic [2:0]   instr_now;
    logic         tck, tms_pin, tms_drv, tdi_pin, tdi_drv, tdo, tdo_oe, drv, hiz;
    int           err_count  = 0;
    int           n_compared = 0;
    // ======================================
    // Clock, design and controller
    always #50 ref_clk = ~ref_clk;
    bst_tap u_bst_tap (.ref_clk(ref_clk), .rst_n(rst_n), .tck(tck), .tms_pin(tms_pin),
        .tms_drv(tms_drv), .tdi_pin(tdi_pin), .tdi_drv(tdi_drv), .tdo(tdo), .tdo_oe(tdo_oe),
        .pad_in(pad_in), .pad_out(pad_out), .pad_test_drive(drv), .pad_hiz(hiz),
        .instr_now(instr_now));
    bst_ctl_model u_ctl (.tck(tck), .tms_pin(tms_pin), .tms_drv(tms_drv),
        .tdi_pin(tdi_pin), .tdi_drv(tdi_drv), .tdo(tdo));
    task automatic check(input string what, input logic [127:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, seen);
            err_count++;
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Instruction load, then let the pad side settle
    task automatic load_ir(input logic [2:0] c);
        logic [127:0] d;
        u_ctl.scan(1'b1, 3, {125'h0, c}, d);
        check("ir_capture", d[1:0], bst_pkg::IR_CAPTURE);
        repeat (8) @(posedge ref_clk);
        check("instr", instr_now, c);
    endtask
    // ======================================
    // Scenarios
    task automatic t_id();
        logic [127:0] d;
        check("reset_instr", instr_now, bst_pkg::INS_RESET);
        u_ctl.scan(1'b0, 64, {96'h0, 32'hc3a5_0f96}, d);
        check("idcode", d[31:1], {bst_pkg::ID_REV, bst_pkg::ID_DEV, bst_pkg::ID_MFR});
        check("id_bit0", d[0], 1'b1);
        check("id_through", d[63:32], 32'hc3a5_0f96);
    endtask
    task automatic t_modes();
        // Reserved codes are never loaded
        logic [2:0] codes [4] = '{3'h0, 3'h2, 3'h4, 3'h7};
        foreach (codes[k]) begin
            load_ir(codes[k]);
            check("hiz", hiz, codes[k] == bst_pkg::INS_SAMPZ);
            check("drive", drv, codes[k] == bst_pkg::INS_EXTEST);
        end
    endtask
    task automatic t_bypass();
        logic [127:0] d;
        load_ir(bst_pkg::INS_BYPASS);
        u_ctl.scan(1'b0, 8, 128'h0000_00b3, d);
        check("bypass", d[7:0], 8'h66);
    endtask
    // Sample pads, preload through the whole chain, then drive it out
    task automatic t_boundary();
        logic [127:0] d;
        logic [W-1:0] pv, pre;
        for (int i = 0; i < W; i++) begin
            pv[i] = (i % 3 == 0);
            pre[i] = (i % 5 == 1);
        end
        mask = ~({{(W - 1){1'b0}}, 1'b1} << bst_pkg::BND_INT); // Cell 48 has no pad
        @(posedge ref_clk) pad_in <= pv;
        load_ir(bst_pkg::INS_SAMPLE);
        u_ctl.scan(1'b0, W + 1, {20'h0, pre, 1'b1}, d);
        check("sample", d[W-1:0] & mask, pv & mask);
        check("chain_len", d[W], 1'b1);
        check("sample_out", pad_out, '0);
        load_ir(bst_pkg::INS_EXTEST);
        check("extest_out", pad_out & mask, pre & mask);
    endtask
    task automatic t_undriven();
        load_ir(bst_pkg::INS_BYPASS);
        u_ctl.tlr(1'b0);
        repeat (2) @(posedge ref_clk);
        check("undriven_tlr", instr_now, bst_pkg::INS_IDCODE);
    endtask
    initial begin
        #1_000_000;
        err_count++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        u_ctl.tlr(1'b1);
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        u_ctl.tlr(1'b1);
        t_id();
        t_modes();
        t_bypass();
        t_boundary();
        t_undriven();
        conclude();
    end
endmodule
`default_nettype wire
